// ---- src/ccc_channel_clock_output_config.sv ----
/*
  Channel clock output configuration: register file for the four channels
  and eight clock outputs, channel dividers with phase delay, output gating.
  Assumes a serial port front end that presents byte writes and reads on a
  plain address/strobe port synchronous to mclk_i, and that the input clock
  being distributed is mclk_i itself. Channel clocks are shown as one-cycle
  ticks, one per divided period.
*/
`timescale 1ns/1ps
`default_nettype none

module ccc_channel_clock_output_config
  import ccc_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   reset_i,
  input  wire logic                   mid_channel_divider_strap_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [7:0]             reg_wdata_i,
  output logic      [7:0]             reg_rdata_o,
  output logic      [NUM_CH-1:0]      channel_power_down_o,
  output logic      [NUM_CH-1:0]      channel_tick_o,
  output logic      [NUM_OUT-1:0]     clock_output_o,
  output ccc_out_cfg_s [NUM_OUT-1:0]  out_cfg_o
);

  ccc_state_s s_q;
  ccc_state_s s_d;

  // Divide ratio for a select code; unused codes fall back to bypass
  function automatic logic [4:0] div_ratio(input logic [3:0] code);
    logic [4:0] r;
    r = 5'd1;
    case (code)
      4'h1:    r = 5'd2;
      4'h2:    r = 5'd3;
      4'h3:    r = 5'd4;
      4'h4:    r = 5'd6;
      4'h5:    r = 5'd8;
      4'h6:    r = 5'd12;
      4'h7:    r = 5'd16;
      4'h8:    r = 5'd24;
      default: r = 5'd1;
    endcase
    return r;
  endfunction : div_ratio

  logic [NUM_CH-1:0]  ch_restart;
  logic [NUM_CH-1:0]  ch_tick;
  logic [NUM_CH-1:0]  wr_div;
  logic [NUM_CH-1:0]  wr_dly;
  logic [NUM_CH-1:0]  wr_cpd;
  logic [NUM_OUT-1:0] wr_oset;
  logic [NUM_OUT-1:0] out_pass;
  logic [7:0]         rd_mux;

  // Address decode per channel and per output
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch_dec
      localparam logic [7:0] CH_OFS = 8'(g * OFS_CH_STRIDE);
      assign wr_div[g] = reg_wr_i && (reg_addr_i == OFS_DIV_BASE + CH_OFS);
      assign wr_dly[g] = reg_wr_i && (reg_addr_i == OFS_DLY_BASE + CH_OFS);
      assign wr_cpd[g] = reg_wr_i && (reg_addr_i == OFS_CPD_BASE + CH_OFS);
      // A new divide or delay setting restarts the channel phase
      assign ch_restart[g] = wr_div[g] || wr_dly[g] || s_q.cpd[g];
      assign ch_tick[g]    = s_q.running[g] && (s_q.cnt[g] == 5'd0)
                             && !s_q.cpd[g];
    end
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      localparam int SRC = int'(OUT_SHARE_SRC[g]);
      logic [1:0] sw;
      logic       pecl;
      assign wr_oset[g] = reg_wr_i && (reg_addr_i == OFS_OUT_SET[g]);
      assign sw   = s_q.oset[SRC][SWING_LSB +: 2];
      assign pecl = s_q.oset[SRC][STYLE_BIT];
      assign out_pass[g] = ch_tick[OUT_CH[g]]
                           && !s_q.oset[g][OPD_BIT]
                           && s_q.en[NUM_OUT-1-g];
      always_comb begin
        out_cfg_o[g].power_down     = s_q.oset[g][OPD_BIT]
                                      || s_q.cpd[OUT_CH[g]];
        out_cfg_o[g].lvpecl         = pecl;
        out_cfg_o[g].swing_code     = sw;
        out_cfg_o[g].swing_reserved = 1'b0;
        case (sw)
          SWING_350: out_cfg_o[g].swing_mv = MV_350;
          SWING_750: out_cfg_o[g].swing_mv = MV_750;
          default: begin
            if (pecl) begin
              out_cfg_o[g].swing_mv = MV_1000;
            end else begin
              out_cfg_o[g].swing_mv       = MV_NONE;
              out_cfg_o[g].swing_reserved = 1'b1;
            end
          end
        endcase
      end
    end
  endgenerate

  // Read mux; anything unmapped or reserved reads as zero
  always_comb begin
    rd_mux = RD_UNMAPPED;
    for (int c = 0; c < NUM_CH; c++) begin
      if (reg_addr_i == OFS_DIV_BASE + 8'(c * OFS_CH_STRIDE)) begin
        rd_mux = {4'h0, s_q.div[c]};
      end
      if (reg_addr_i == OFS_DLY_BASE + 8'(c * OFS_CH_STRIDE)) begin
        rd_mux = s_q.dly[c];
      end
      if (reg_addr_i == OFS_CPD_BASE + 8'(c * OFS_CH_STRIDE)) begin
        rd_mux = {s_q.cpd[c], 7'h00};
      end
    end
    for (int o = 0; o < NUM_OUT; o++) begin
      if (reg_addr_i == OFS_OUT_SET[o]) begin
        rd_mux = s_q.oset[o];
      end
    end
    if (reg_addr_i == OFS_OUT_ENABLE) begin
      rd_mux = s_q.en;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = reg_rd_i ? rd_mux : s_q.rdata;
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr_div[c]) begin
        s_d.div[c] = reg_wdata_i[DIV_LSB +: 4];
      end
      if (wr_dly[c]) begin
        s_d.dly[c] = reg_wdata_i;
      end
      if (wr_cpd[c]) begin
        s_d.cpd[c] = reg_wdata_i[CPD_BIT];
      end
      // Phase delay counts input periods before the divider starts
      if (ch_restart[c]) begin
        s_d.wait_cnt[c] = wr_dly[c] ? reg_wdata_i : s_q.dly[c];
        s_d.running[c]  = 1'b0;
        s_d.cnt[c]      = 5'd0;
      end else if (!s_q.running[c]) begin
        if (s_q.wait_cnt[c] == 8'h00) begin
          s_d.running[c] = 1'b1;
        end else begin
          s_d.wait_cnt[c] = s_q.wait_cnt[c] - 8'h01;
        end
      end else if (s_q.cnt[c] == div_ratio(s_q.div[c]) - 5'd1) begin
        s_d.cnt[c] = 5'd0;
      end else begin
        s_d.cnt[c] = s_q.cnt[c] + 5'd1;
      end
    end
    for (int o = 0; o < NUM_OUT; o++) begin
      if (wr_oset[o]) begin
        s_d.oset[o] = reg_wdata_i & OUT_SET_MASK[o];
      end
    end
    if (reg_wr_i && (reg_addr_i == OFS_OUT_ENABLE)) begin
      s_d.en = reg_wdata_i;
    end
    s_d.clk_out = out_pass;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.div[0] <= DIV_RST_BYPASS;
      s_q.div[1] <= {DIV_RST_MID_HI, mid_channel_divider_strap_i};
      s_q.div[2] <= {DIV_RST_MID_HI, mid_channel_divider_strap_i};
      s_q.div[3] <= DIV_RST_BYPASS;
      for (int c = 0; c < NUM_CH; c++) begin
        s_q.dly[c]      <= DLY_RST;
        s_q.wait_cnt[c] <= DLY_RST;
      end
      s_q.cpd <= '0;
      for (int o = 0; o < NUM_OUT; o++) begin
        s_q.oset[o] <= OUT_SET_RST & OUT_SET_MASK[o];
      end
      s_q.en <= EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o          = s_q.rdata;
  assign channel_power_down_o = s_q.cpd;
  assign channel_tick_o       = ch_tick;
  assign clock_output_o       = s_q.clk_out;

endmodule : ccc_channel_clock_output_config

`default_nettype wire

// ---- src/ccc_pkg.sv ----
/*
  Package for the channel clock output configuration block: register
  offsets, field positions, reset values and the shared structs.
  Assumes an 8-bit register map reached through the serial port front end.
*/
package ccc_pkg;

  localparam int NUM_CH  = 4;
  localparam int NUM_OUT = 8;

  // Channel register offsets, channel stride is 0x10
  localparam logic [7:0] OFS_DIV_BASE   = 8'h20;
  localparam logic [7:0] OFS_DLY_BASE   = 8'h21;
  localparam logic [7:0] OFS_CPD_BASE   = 8'h22;
  localparam logic [7:0] OFS_CH_STRIDE  = 8'h10;
  localparam logic [7:0] OFS_OUT_ENABLE = 8'h74;

  // Output settings register offsets, order A0 A1 A2 B0 B1 C0 C1 D
  localparam logic [NUM_OUT-1:0][7:0] OFS_OUT_SET = {
    8'h54, 8'h45, 8'h44, 8'h35, 8'h34, 8'h26, 8'h25, 8'h24};
  // Owning channel of each output
  localparam logic [NUM_OUT-1:0][1:0] OUT_CH = {
    2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
  // Writable bits of each output settings byte (A1 and B1 share with A0/B0)
  localparam logic [NUM_OUT-1:0][7:0] OUT_SET_MASK = {
    8'h9C, 8'h9C, 8'h9C, 8'h80, 8'h9C, 8'h9C, 8'h80, 8'h9C};
  // Output whose format and swing an output actually uses
  localparam logic [NUM_OUT-1:0][2:0] OUT_SHARE_SRC = {
    3'h7, 3'h6, 3'h5, 3'h3, 3'h3, 3'h2, 3'h0, 3'h0};

  // Field positions
  localparam int DIV_LSB   = 0;
  localparam int CPD_BIT   = 7;
  localparam int OPD_BIT   = 7;
  localparam int STYLE_BIT = 4;
  localparam int SWING_LSB = 2;
  localparam logic [7:0] DIV_MASK = 8'h0F;
  localparam logic [7:0] CPD_MASK = 8'h80;

  // Reset values
  localparam logic [3:0] DIV_RST_BYPASS = 4'h0;
  localparam logic [2:0] DIV_RST_MID_HI = 3'h1;
  localparam logic [7:0] DLY_RST        = 8'h00;
  localparam logic [7:0] OUT_SET_RST    = 8'h04;
  localparam logic [7:0] EN_RST         = 8'hFF;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;

  // Swing codes and levels in mV
  localparam logic [1:0] SWING_350  = 2'h0;
  localparam logic [1:0] SWING_750  = 2'h1;
  localparam logic [9:0] MV_350     = 10'h15E;
  localparam logic [9:0] MV_750     = 10'h2EE;
  localparam logic [9:0] MV_1000    = 10'h3E8;
  localparam logic [9:0] MV_NONE    = 10'h000;

  typedef struct packed {
    logic       power_down;
    logic       lvpecl;
    logic [1:0] swing_code;
    logic [9:0] swing_mv;
    logic       swing_reserved;
  } ccc_out_cfg_s;

  typedef struct packed {
    logic [NUM_CH-1:0][3:0]  div;
    logic [NUM_CH-1:0][7:0]  dly;
    logic [NUM_CH-1:0]       cpd;
    logic [NUM_OUT-1:0][7:0] oset;
    logic [7:0]              en;
    logic [NUM_CH-1:0][7:0]  wait_cnt;
    logic [NUM_CH-1:0]       running;
    logic [NUM_CH-1:0][4:0]  cnt;
    logic [NUM_OUT-1:0]      clk_out;
    logic [7:0]              rdata;
  } ccc_state_s;

endpackage : ccc_pkg

// ---- tb/ccc_config_props.sv ----
/* Checker for the channel clock output config block, bound to its top.
   Assumes one clock domain and the design's synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module ccc_config_props
  import ccc_pkg::*;
(
  input wire logic                       mclk_i,
  input wire logic                       reset_i,
  input wire logic                       reg_rd_i,
  input wire logic [7:0]                 reg_addr_i,
  input wire logic [7:0]                 reg_rdata_o,
  input wire logic [NUM_CH-1:0]          channel_power_down_o,
  input wire logic [NUM_CH-1:0]          channel_tick_o,
  input wire logic [NUM_OUT-1:0]         clock_output_o,
  input wire ccc_out_cfg_s [NUM_OUT-1:0] out_cfg_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  cfg_reset_val_a: assert property ($past(reset_i) |->
    out_cfg_o[0].swing_code == SWING_750 && !out_cfg_o[0].lvpecl)
    else $error("output settings not at reset value");
  opd_gates_out_a: assert property (
    out_cfg_o[2].power_down |=> !clock_output_o[2])
    else $error("powered down output toggles");
  tick_to_out_a: assert property (clock_output_o[0] |->
    $past(channel_tick_o[0]) && !$past(out_cfg_o[0].power_down))
    else $error("output pulse without channel tick");
  cpd_no_tick_a: assert property (
    channel_power_down_o[1] |-> !channel_tick_o[1])
    else $error("tick on powered down channel");
  share_fmt_b_a: assert property (
    out_cfg_o[4].lvpecl == out_cfg_o[3].lvpecl)
    else $error("pair format differs");
  share_swing_b_a: assert property (
    out_cfg_o[4].swing_code == out_cfg_o[3].swing_code)
    else $error("pair swing differs");
  swing_map_a: assert property (
    out_cfg_o[2].swing_mv == (out_cfg_o[2].swing_code == 2'h0 ? MV_350 :
    out_cfg_o[2].swing_code == 2'h1 ? MV_750 :
    out_cfg_o[2].lvpecl ? MV_1000 : MV_NONE))
    else $error("swing level wrong");
  unmapped_rd_a: assert property (
    reg_rd_i && reg_addr_i == 8'h23 |=> reg_rdata_o == 8'h00)
    else $error("reserved address reads nonzero");
endmodule : ccc_config_props

bind ccc_channel_clock_output_config ccc_config_props ccc_config_props_inst (
  .mclk_i, .reset_i, .reg_rd_i, .reg_addr_i, .reg_rdata_o,
  .channel_power_down_o, .channel_tick_o, .clock_output_o, .out_cfg_o
);
`default_nettype wire

// ---- tb/tb_channel_clock_output_config.sv ----
/* Self-checking bench for the channel clock output config block.
   Drives the byte register port and strap itself; no partner model. */
`timescale 1ns/1ps
`default_nettype none
module tb_channel_clock_output_config
  import ccc_pkg::*;
;
  logic                       mclk_i;
  logic                       reset_i = 1'b1;
  logic                       mid_channel_divider_strap_i = 1'b0;
  logic                       reg_wr_i = 1'b0;
  logic                       reg_rd_i = 1'b0;
  logic [7:0]                 reg_addr_i = 8'h00;
  logic [7:0]                 reg_wdata_i = 8'h00;
  logic [7:0]                 reg_rdata_o;
  logic [NUM_CH-1:0]          channel_power_down_o;
  logic [NUM_CH-1:0]          channel_tick_o;
  logic [NUM_OUT-1:0]         clock_output_o;
  ccc_out_cfg_s [NUM_OUT-1:0] out_cfg_o;
  int                         n_errors = 0;
  int                         tests_run = 0;
  logic [31:0]                seed = 32'h2A94;
  logic [7:0]                 a;
  logic [7:0]                 r;
  int                         n;
  int                         i;
  int                         j;
  int                         k;
  int                         dv[9] = '{1, 2, 3, 4, 6, 8, 12, 16, 24};

  ccc_channel_clock_output_config ccc_channel_clock_output_config_inst (
    .mclk_i, .reset_i, .mid_channel_divider_strap_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .channel_power_down_o,
    .channel_tick_o, .clock_output_o, .out_cfg_o);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [9:0] mv(input logic f, input logic [1:0] s);
    return s == 2'h0 ? MV_350 : s == 2'h1 ? MV_750 : f ? MV_1000 : MV_NONE;
  endfunction : mv
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Each access spends one idle cycle so no strobe is set twice at once
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge mclk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = ad;
    reg_wdata_i = d;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(negedge mclk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = ad;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, exp);
  endtask : rd
  task automatic gap(input int ch, input int lim);
    n = 0;
    while (channel_tick_o[ch] !== 1'b1 && n < lim) begin
      @(negedge mclk_i);
      n++;
    end
  endtask : gap
  task automatic finish_test;
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    #200us;
    n_errors++;
    finish_test();
  end
  initial begin
    for (k = 0; k < 2; k++) begin
      reset_i = 1'b1;
      mid_channel_divider_strap_i = k[0];
      repeat (20) @(negedge mclk_i);
      reset_i = 1'b0;
      for (i = 0; i < NUM_CH; i++) begin
        a = OFS_CH_STRIDE * i[7:0];
        r = (i == 1 || i == 2) ? {4'h0, DIV_RST_MID_HI, k[0]}
                               : {4'h0, DIV_RST_BYPASS};
        rd(OFS_DIV_BASE + a, r);
        rd(OFS_DLY_BASE + a, DLY_RST);
        rd(OFS_CPD_BASE + a, 8'h00);
      end
      for (i = 0; i < NUM_OUT; i++) begin
        rd(OFS_OUT_SET[i], OUT_SET_MASK[i] & OUT_SET_RST);
      end
      rd(OFS_OUT_ENABLE, 8'hFF);
      // Dirty the map so the second reset has something to restore
      wr(OFS_OUT_SET[0], 8'h98);
      wr(OFS_DLY_BASE, 8'h5A);
      wr(OFS_OUT_ENABLE, 8'h00);
    end
    repeat (16) begin
      seed = lfsr(seed);
      r = seed[7:0];
      i = seed[10:8];
      a = OFS_CH_STRIDE * seed[12:11];
      wr(OFS_OUT_SET[i], r);
      rd(OFS_OUT_SET[i], r & OUT_SET_MASK[i]);
      wr(OFS_DIV_BASE + a, r);
      rd(OFS_DIV_BASE + a, r & DIV_MASK);
      wr(OFS_CPD_BASE + a, r);
      rd(OFS_CPD_BASE + a, r & CPD_MASK);
      wr(OFS_DLY_BASE + a, r);
      rd(OFS_DLY_BASE + a, r);
      wr(8'h23, r);
      rd(8'h23, 8'h00);
    end
    for (i = 0; i < NUM_CH; i++) begin
      a = OFS_CH_STRIDE * i[7:0];
      wr(OFS_DIV_BASE + a, 8'h00);
      wr(OFS_DLY_BASE + a, 8'h00);
      wr(OFS_CPD_BASE + a, 8'h00);
    end
    for (i = 0; i < NUM_OUT; i++) wr(OFS_OUT_SET[i], OUT_SET_RST);
    for (k = 0; k < 9; k++) begin
      seed = lfsr(seed);
      r = (k == 0) ? 8'h00 : (k == 8) ? 8'hFF : seed[7:0];
      wr(OFS_OUT_ENABLE, r);
      repeat (3) @(negedge mclk_i);
      for (i = 0; i < NUM_OUT; i++) chk(clock_output_o[i], r[7-i]);
    end
    wr(OFS_OUT_SET[2], 8'h84);
    repeat (3) @(negedge mclk_i);
    chk(clock_output_o[2], 1'b0);
    wr(OFS_OUT_SET[2], 8'h04);
    wr(8'h32, 8'h80);
    repeat (4) @(negedge mclk_i);
    chk({channel_power_down_o, clock_output_o[4:3]}, 6'h08);
    chk(out_cfg_o[3].power_down, 1'b1);
    wr(8'h32, 8'h00);
    for (k = 0; k < 9; k++) begin
      wr(8'h40, k[7:0]);
      gap(2, 40);
      @(negedge mclk_i);
      gap(2, 40);
      chk(n + 1, dv[k]);
    end
    wr(8'h30, 8'h03);
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      r = (k == 2) ? 8'hFF : (k == 3) ? seed[7:0] : k[7:0];
      wr(8'h31, r);
      gap(1, 300);
      chk(n, r + 1);
    end
    for (j = 0; j < 2; j++) begin
      for (k = 0; k < 8; k++) begin
        wr(OFS_OUT_SET[3 * j], {3'h0, k[2:0], 2'h0});
        for (i = 3 * j; i < 3 * j + 2; i++) begin
          chk(out_cfg_o[i].lvpecl, k[2]);
          chk(out_cfg_o[i].swing_mv, mv(k[2], k[1:0]));
          chk(out_cfg_o[i].swing_reserved, !k[2] && k[1]);
        end
      end
    end
    finish_test();
  end
endmodule : tb_channel_clock_output_config
`default_nettype wire
